// file: design/power_up_slot_sequencer.sv
// Power-up slot sequencer: fuse load, slot enables, reset release, address, soft start
`timescale 1ns/10ps

// Function
// - Nonzero slot code n enables after n slots
// - Zero code stays off; bus enable later
// - Slot period 500 us or 2000 us
// - Reset released 2 ms after last slot
// - Level mode: enable high on, low off
// - Edge mode: fall on, 4 s low off
// - Slave address is 0x08 plus field
// - New address used right after write
// - Default-address bit forces address 0x08
// - Buck ramp 25 mV per 2/4 us
// - Cold start loads fuses on input ok
// - Turn-on reloads shadow from fuses, except in try-before-buy
// - Sequence runs from shadow register contents
// - Memory reference follows third buck slot
// - Card rail range follows select pin
// - Slots are counted in 32 kHz ticks
// - Try-before-buy skips fuse load
// - Sleep-kept regulators stay on at turn-on
module power_up_slot_sequencer #(
    parameter int HOLD_TICKS = pwr_seq_pkg::HOLD_TICKS_DFLT
) (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    input  wire logic                          ce,
    input  wire logic                          tick_32k,
    input  wire logic                          en_pin,
    input  wire logic                          input_voltage_threshold,
    input  wire logic                          tbb_mode,
    input  wire logic [pwr_seq_pkg::FUSE_W-1:0] fuse_data,
    input  wire logic [pwr_seq_pkg::NUM_CH-1:0] sleep_keep_mask,
    input  wire logic                          card_voltage_select,
    input  wire logic                          addr_cfg_wr,
    input  wire logic [7:0]                    addr_cfg_wdata,
    input  wire logic                          reg_en_wr,
    input  wire logic [pwr_seq_pkg::NUM_CH-1:0] reg_en_wdata,
    output logic      [pwr_seq_pkg::NUM_CH-1:0] reg_enable,
    output logic                               memref_enable,
    output logic                               processor_reset_out,
    output logic                               processor_reset_oe,
    output logic                               seq_done,
    output logic      [6:0]                    slave_address,
    output logic      [7:0]                    addr_cfg_rdata,
    output logic                               card_low_range,
    output logic      [2:0][5:0]               buck_ramp_code
);
    // ********************************************************
    // Declarations
    // ********************************************************
    localparam int NCH = pwr_seq_pkg::NUM_CH;

    pwr_seq_pkg::state_e  state_r;
    pwr_seq_pkg::state_e  state_nxt;
    pwr_seq_pkg::shadow_s shadow_r;
    pwr_seq_pkg::shadow_s shadow_nxt;
    logic [NCH-1:0]       reg_en_r;
    logic [NCH-1:0]       reg_en_nxt;
    logic [NCH-1:0]       kept_r;
    logic [NCH-1:0]       kept_nxt;
    logic [6:0]           rst_cnt_r;
    logic [6:0]           rst_cnt_nxt;
    logic [16:0]          hold_cnt_r;
    logic [16:0]          hold_cnt_nxt;
    logic                 released_r;
    logic                 released_nxt;
    logic                 en_prev_r;
    logic                 vin_prev_r;
    logic [6:0]           slave_addr_r;
    logic [6:0]           slave_addr_nxt;
    logic                 card_low_r;
    logic [9:0]           step_cnt_r;
    logic [9:0]           step_cnt_nxt;
    logic                 step_r;
    logic                 step_nxt;
    logic [3:0]           chan_code [NCH];
    logic [NCH-1:0]       slot_match;
    logic [3:0]           last_slot;
    logic                 on_evt;
    logic                 off_evt;
    logic [2:0]           ramping;
    logic [9:0]           step_limit;

    slot_if sif ();

    slot_timer u_slot_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .sif      (sif)
    );

    // ********************************************************
    // Slot codes from the shadow registers
    // ********************************************************
    // codes from shadow
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_code
            if (i <= pwr_seq_pkg::CH_BUCK3) begin : g_buck
                assign chan_code[i] = {1'b0, shadow_r.buck_slot_code[i]};
            end else if (i == pwr_seq_pkg::CH_RAIL33) begin : g_r33
                assign chan_code[i] = {1'b0, shadow_r.rail33_slot_code};
            end else if (i == pwr_seq_pkg::CH_CARD) begin : g_card
                assign chan_code[i] = {1'b0, shadow_r.card_rail_slot_code};
            end else begin : g_lin
                assign chan_code[i] = shadow_r.linear_slot_code[i - pwr_seq_pkg::CH_LIN0];
            end
            assign slot_match[i] = (chan_code[i] != 4'h0) && (chan_code[i] == sif.slot_num);
        end
    endgenerate

    // Highest programmed slot ends the sequence
    always_comb begin
        last_slot = 4'h0;
        for (int i = 0; i < NCH; i++) begin
            if (chan_code[i] > last_slot) begin
                last_slot = chan_code[i];
            end
        end
    end

    assign sif.tick   = tick_32k;
    assign sif.clear  = (state_r != pwr_seq_pkg::ST_SEQ);
    assign sif.period = shadow_r.slot_speed ? pwr_seq_pkg::SLOT1_TICKS : pwr_seq_pkg::SLOT0_TICKS;

    // ********************************************************
    // Turn-on and turn-off events
    // ********************************************************
    // level mode, edge mode
    assign on_evt  = input_voltage_threshold &&
                     (shadow_r.en_mode ? (en_prev_r && !en_pin) : en_pin);
    assign off_evt = shadow_r.en_mode ?
                     (!en_pin && tick_32k && hold_cnt_r == 17'(HOLD_TICKS - 1)) : !en_pin;

    // ********************************************************
    // Sequencer state
    // ********************************************************
    // Next state, shadow, enables and reset release
    always_comb begin
        state_nxt      = state_r;
        shadow_nxt     = shadow_r;
        reg_en_nxt     = reg_en_r;
        kept_nxt       = kept_r;
        rst_cnt_nxt    = rst_cnt_r;
        released_nxt   = released_r;
        hold_cnt_nxt   = '0;
        case (state_r)
            pwr_seq_pkg::ST_OFF: begin
                // cold start load, skipped in try-before-buy
                if (input_voltage_threshold && !vin_prev_r && !tbb_mode) begin
                    shadow_nxt = pwr_seq_pkg::shadow_s'(fuse_data);
                end
                if (on_evt) begin
                    kept_nxt  = reg_en_r;
                    state_nxt = tbb_mode ? pwr_seq_pkg::ST_SEQ : pwr_seq_pkg::ST_LOAD;
                end
            end
            pwr_seq_pkg::ST_LOAD: begin
                shadow_nxt = pwr_seq_pkg::shadow_s'(fuse_data);
                state_nxt  = pwr_seq_pkg::ST_SEQ;
            end
            pwr_seq_pkg::ST_SEQ: begin
                rst_cnt_nxt = '0;
                if (last_slot == 4'h0) begin
                    state_nxt = pwr_seq_pkg::ST_RST_WAIT;
                end else if (sif.strobe) begin
                    // slot enable, zero code never matches
                    reg_en_nxt = reg_en_r | slot_match;
                    if (sif.slot_num == last_slot) begin
                        state_nxt = pwr_seq_pkg::ST_RST_WAIT;
                    end
                end
            end
            pwr_seq_pkg::ST_RST_WAIT: begin
                if (tick_32k) begin
                    rst_cnt_nxt = 7'(rst_cnt_r + 7'h01);
                    if (rst_cnt_r == 7'(pwr_seq_pkg::RST_TICKS - 7'h01)) begin
                        released_nxt = 1'b1;
                        state_nxt    = pwr_seq_pkg::ST_ON;
                    end
                end
            end
            pwr_seq_pkg::ST_ON: begin
                if (reg_en_wr) begin
                    reg_en_nxt = reg_en_wdata;
                end
            end
            default: begin
                state_nxt = pwr_seq_pkg::ST_OFF;
            end
        endcase
        if (state_r != pwr_seq_pkg::ST_OFF && shadow_r.en_mode && !en_pin) begin
            hold_cnt_nxt = tick_32k ? 17'(hold_cnt_r + 17'h00001) : hold_cnt_r;
        end
        if (state_r != pwr_seq_pkg::ST_OFF && state_r != pwr_seq_pkg::ST_LOAD && off_evt) begin
            state_nxt    = pwr_seq_pkg::ST_OFF;
            reg_en_nxt   = reg_en_r & sleep_keep_mask;
            released_nxt = 1'b0;
            hold_cnt_nxt = '0;
        end
        if (addr_cfg_wr) begin
            shadow_nxt.addr_cfg = addr_cfg_wdata;
        end
    end

    always_comb begin
        if (shadow_nxt.addr_cfg[pwr_seq_pkg::ADDR_DEF_BIT]) begin
            slave_addr_nxt = pwr_seq_pkg::ADDR_DEFAULT;
        end else begin
            slave_addr_nxt = {pwr_seq_pkg::ADDR_HIGH, shadow_nxt.addr_cfg[2:0]};
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r      <= pwr_seq_pkg::ST_OFF;
            shadow_r     <= pwr_seq_pkg::SHADOW_RST;
            reg_en_r     <= '0;
            kept_r       <= '0;
            rst_cnt_r    <= '0;
            hold_cnt_r   <= '0;
            released_r   <= 1'b0;
            en_prev_r    <= 1'b0;
            vin_prev_r   <= 1'b0;
            slave_addr_r <= pwr_seq_pkg::ADDR_DEFAULT;
            card_low_r   <= 1'b1;
        end else if (ce) begin
            state_r      <= state_nxt;
            shadow_r     <= shadow_nxt;
            reg_en_r     <= reg_en_nxt;
            kept_r       <= kept_nxt;
            rst_cnt_r    <= rst_cnt_nxt;
            hold_cnt_r   <= hold_cnt_nxt;
            released_r   <= released_nxt;
            en_prev_r    <= en_pin;
            vin_prev_r   <= input_voltage_threshold;
            slave_addr_r <= slave_addr_nxt;
            card_low_r   <= card_voltage_select;
        end
    end

    // ********************************************************
    // Buck soft start ramp
    // ********************************************************
    // step interval select
    assign step_limit = shadow_r.ramp_sel ? pwr_seq_pkg::STEP1_CYC : pwr_seq_pkg::STEP0_CYC;

    // Step pacing while any buck ramps
    always_comb begin
        step_cnt_nxt = '0;
        step_nxt     = 1'b0;
        if (ramping != 3'b000) begin
            if (step_cnt_r == 10'(step_limit - 10'h001)) begin
                step_nxt = 1'b1;
            end else begin
                step_cnt_nxt = 10'(step_cnt_r + 10'h001);
            end
        end
    end

    // Step timer registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            step_cnt_r <= '0;
            step_r     <= 1'b0;
        end else if (ce) begin
            step_cnt_r <= step_cnt_nxt;
            step_r     <= step_nxt;
        end
    end

    // One 25 mV code step per pulse up to the target
    generate
        for (genvar b = 0; b < 3; b++) begin : g_ramp
            logic [5:0] ramp_r;
            logic [5:0] ramp_nxt;
            assign ramping[b] = reg_en_r[b] && (ramp_r != shadow_r.buck_target[b]);
            always_comb begin
                ramp_nxt = ramp_r;
                if (!reg_en_r[b]) begin
                    ramp_nxt = '0;
                end else if (step_r && ramp_r < shadow_r.buck_target[b]) begin
                    ramp_nxt = 6'(ramp_r + 6'h01);
                end
            end
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    ramp_r <= '0;
                end else if (ce) begin
                    ramp_r <= ramp_nxt;
                end
            end
            assign buck_ramp_code[b] = ramp_r;
        end
    endgenerate

    // ********************************************************
    // Outputs
    // ********************************************************
    assign reg_enable          = reg_en_r;
    assign memref_enable       = reg_en_r[pwr_seq_pkg::CH_BUCK3];
    assign processor_reset_out = released_r;
    assign processor_reset_oe  = !released_r;
    assign seq_done            = (state_r == pwr_seq_pkg::ST_ON);
    assign slave_address       = slave_addr_r;
    assign addr_cfg_rdata      = shadow_r.addr_cfg;
    assign card_low_range      = card_low_r;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_load_step;
        state_r == pwr_seq_pkg::ST_LOAD;
    endsequence
    sequence s_seq_step;
        state_r == pwr_seq_pkg::ST_SEQ;
    endsequence

    a_zero_code_off: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        state_r == pwr_seq_pkg::ST_SEQ && chan_code[pwr_seq_pkg::CH_RAIL33] == 4'h0 &&
        !kept_r[pwr_seq_pkg::CH_RAIL33] && !reg_en_r[pwr_seq_pkg::CH_RAIL33]
        |=> !reg_en_r[pwr_seq_pkg::CH_RAIL33])
        else $error("zero-code regulator enabled during sequence");
    a_slot_pair_on: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        state_r == pwr_seq_pkg::ST_SEQ && sif.strobe && !off_evt
        |=> (reg_en_r & $past(slot_match)) == $past(slot_match))
        else $error("equal-code regulators not enabled together");
    a_period_sel: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        sif.period == (shadow_r.slot_speed ? 7'h40 : 7'h10))
        else $error("slot period wrong");
    a_reset_delay: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        $rose(released_r) |-> $past(state_r) == pwr_seq_pkg::ST_RST_WAIT && $past(rst_cnt_r) == 7'h3F)
        else $error("reset released at wrong time");
    a_level_on: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        state_r == pwr_seq_pkg::ST_OFF && !shadow_r.en_mode && en_pin && input_voltage_threshold
        |=> state_r != pwr_seq_pkg::ST_OFF)
        else $error("level enable did not turn on");
    a_edge_on: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        state_r == pwr_seq_pkg::ST_OFF && shadow_r.en_mode && en_prev_r && !en_pin &&
        input_voltage_threshold |=> state_r != pwr_seq_pkg::ST_OFF)
        else $error("falling edge did not turn on");
    a_addr_default: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        shadow_r.addr_cfg[7] |-> slave_addr_r == 7'h08)
        else $error("default address not used");
    a_addr_range: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        slave_addr_r[6:3] == 4'h1)
        else $error("slave address out of range");
    a_addr_update: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        addr_cfg_wr && !addr_cfg_wdata[7] |=> slave_addr_r == {4'h1, $past(addr_cfg_wdata[2:0])})
        else $error("new address not taken");
    a_reload: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        s_load_step ##1 s_seq_step |-> shadow_r.buck_slot_code == $past(fuse_data[8:0]))
        else $error("shadow not reloaded from fuses");
    a_memref: assert property (@(posedge core_clk) disable iff (!resetn)
        memref_enable == reg_enable[2])
        else $error("memory reference not with third buck");
    a_step_gap: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        step_r |-> $past(step_cnt_r) == ($past(shadow_r.ramp_sel) ? 10'h31F : 10'h18F))
        else $error("ramp steps at wrong interval");
endmodule

// file: design/pwr_seq_pkg.sv
// Constants, configuration layout and states of the power-up slot sequencer
package pwr_seq_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_MHZ        = 200;
    localparam int TICK_HZ        = 32000;
    localparam int SLOT0_US       = 500;
    localparam int SLOT1_US       = 2000;
    localparam int RST_DELAY_US   = 2000;
    localparam int HOLD_OFF_MS    = 4000;
    localparam int STEP0_NS       = 2000;
    localparam int STEP1_NS       = 4000;
    localparam int RAMP_STEP_MV   = 25;
    localparam logic [6:0] SLOT0_TICKS = 7'(SLOT0_US * TICK_HZ / 1000000);
    localparam logic [6:0] SLOT1_TICKS = 7'(SLOT1_US * TICK_HZ / 1000000);
    localparam logic [6:0] RST_TICKS   = 7'(RST_DELAY_US * TICK_HZ / 1000000);
    localparam int HOLD_TICKS_DFLT     = HOLD_OFF_MS * TICK_HZ / 1000;
    localparam logic [9:0] STEP0_CYC   = 10'(STEP0_NS * CLK_MHZ / 1000);
    localparam logic [9:0] STEP1_CYC   = 10'(STEP1_NS * CLK_MHZ / 1000);

    // ********************************************************
    // Channels and addressing
    // ********************************************************
    localparam int NUM_CH         = 9;
    localparam int CH_BUCK0       = 0;
    localparam int CH_BUCK3       = 2;
    localparam int CH_RAIL33      = 3;
    localparam int CH_CARD        = 4;
    localparam int CH_LIN0        = 5;
    localparam int ADDR_DEF_BIT   = 7;
    localparam logic [6:0] ADDR_DEFAULT = 7'h08;
    localparam logic [3:0] ADDR_HIGH    = 4'h1;
    localparam logic [7:0] ADDR_CFG_RST = 8'h00;
    localparam int FUSE_W         = 60;

    // ********************************************************
    // Shadow configuration layout
    // ********************************************************
    typedef struct packed {
        logic [7:0]      addr_cfg;
        logic            ramp_sel;
        logic            en_mode;
        logic            slot_speed;
        logic [2:0][5:0] buck_target;
        logic [3:0][3:0] linear_slot_code;
        logic [2:0]      card_rail_slot_code;
        logic [2:0]      rail33_slot_code;
        logic [2:0][2:0] buck_slot_code;
    } shadow_s;

    localparam shadow_s SHADOW_RST = '{addr_cfg: ADDR_CFG_RST, default: '0};

    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_LOAD     = 3'b001,
        ST_SEQ      = 3'b010,
        ST_RST_WAIT = 3'b011,
        ST_ON       = 3'b100
    } state_e;

endpackage

// file: design/slot_if.sv
// Link between the sequencer and its slot timer
`timescale 1ns/10ps
interface slot_if;
    logic       tick;
    logic       clear;
    logic [6:0] period;
    logic       strobe;
    logic [3:0] slot_num;

    modport seq   (output tick, clear, period, input strobe, slot_num);
    modport timer (input tick, clear, period, output strobe, slot_num);
endinterface

// file: design/slot_timer.sv
// Slot timer counting 32 kHz ticks into numbered slots
`timescale 1ns/10ps
module slot_timer (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    slot_if.timer    sif
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [3:0] slot_r;
    logic [3:0] slot_nxt;
    logic       strobe_r;
    logic       strobe_nxt;

    // Next count, slot number and strobe
    always_comb begin
        cnt_nxt    = cnt_r;
        slot_nxt   = slot_r;
        strobe_nxt = 1'b0;
        if (sif.clear) begin
            cnt_nxt  = '0;
            slot_nxt = '0;
        end else if (sif.tick) begin
            if (cnt_r == 7'(sif.period - 7'h01)) begin
                cnt_nxt    = '0;
                slot_nxt   = (slot_r == 4'hF) ? slot_r : 4'(slot_r + 4'h1);
                strobe_nxt = 1'b1;
            end else begin
                cnt_nxt = 7'(cnt_r + 7'h01);
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r    <= '0;
            slot_r   <= '0;
            strobe_r <= 1'b0;
        end else if (ce) begin
            cnt_r    <= cnt_nxt;
            slot_r   <= slot_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    assign sif.strobe   = strobe_r & ce;
    assign sif.slot_num = slot_r;

    a_slot_step_one: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
        $past(ce) && strobe_r && !$past(strobe_r) && $past(slot_r) != 4'hF
        |-> slot_r == 4'($past(slot_r) + 4'h1))
        else $error("slot number did not advance by one");
endmodule

// file: verif/host_switch_model.sv
// Far-side model: 32 kHz tick source and the enable switch or driver
`timescale 1ns/10ps
module host_switch_model (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic en_req,
    output logic      tick_32k,
    output logic      en_pin
);
    logic [1:0] div_r;

    // ********************************************************
    // Tick divider and enable driver
    // ********************************************************
    // Tick every fourth clock keeps slot counts short in simulation
    // tick from divider
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_r    <= 2'h0;
            tick_32k <= 1'b0;
            en_pin   <= 1'b0;
        end else begin
            div_r    <= div_r + 2'h1;
            tick_32k <= (div_r == 2'h3);
            en_pin   <= en_req;
        end
    end
endmodule

// file: verif/power_up_slot_sequencer_bench.sv
// Self-checking testbench for the power-up slot sequencer
`timescale 1ns/10ps
module power_up_slot_sequencer_bench;
    logic             core_clk, resetn, vin, en_req, sel, aw, ew, tbb;
    logic [59:0]      fuse;
    logic [8:0]       keep, ewd, en;
    logic [7:0]       awd, ard;
    logic [6:0]       sa;
    logic             tick, en_pin, rst_o, rst_oe, done, mref, low;
    logic [2:0][5:0]  ramp;
    int               mismatches, tests_run;

    host_switch_model host_switch_model_i (.core_clk(core_clk), .resetn(resetn),
        .en_req(en_req), .tick_32k(tick), .en_pin(en_pin));
    power_up_slot_sequencer #(.HOLD_TICKS(100)) power_up_slot_sequencer_i (
        .core_clk(core_clk), .resetn(resetn), .ce(1'b1), .tick_32k(tick), .en_pin(en_pin),
        .input_voltage_threshold(vin), .tbb_mode(tbb), .fuse_data(fuse),
        .sleep_keep_mask(keep), .card_voltage_select(sel), .addr_cfg_wr(aw),
        .addr_cfg_wdata(awd), .reg_en_wr(ew), .reg_en_wdata(ewd), .reg_enable(en),
        .memref_enable(mref), .processor_reset_out(rst_o), .processor_reset_oe(rst_oe),
        .seq_done(done), .slave_address(sa), .addr_cfg_rdata(ard),
        .card_low_range(low), .buck_ramp_code(ramp));

    // ********************************************************
    // Tasks
    // ********************************************************
    // Compare one result and count it
    task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Wait whole ticks, then let the edge settle
    task automatic ticks(int n);
        repeat (n * 4) @(posedge core_clk);
        #1;
    endtask
    // One-cycle write strobe on either write port
    task automatic wr(bit is_addr, logic [8:0] d);
        @(posedge core_clk);
        aw  <= is_addr;
        ew  <= !is_addr;
        awd <= d[7:0];
        ewd <= d;
        @(posedge core_clk);
        aw  <= 1'b0;
        ew  <= 1'b0;
        #1;
    endtask
    // Print counts and the verdict, then stop
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********************************************************
    // Clock, watchdog and tests
    // ********************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Whole run needs about 1300 clocks
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        {resetn, vin, en_req, sel, aw, ew, tbb} = 7'h00;
        awd  = 8'h00;
        ewd  = 9'h000;
        keep = 9'h008;
        fuse = 60'h80019091;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk("addr", 9'h008, 9'(sa));
        chk("rst", 9'h000, 9'(rst_o));
        chk("oe", 9'h001, 9'(rst_oe));
        for (int i = 0; i < 9; i++) begin
            wr(1'b1, (i == 8) ? 9'h085 : 9'(i));
            chk("addr", (i == 8) ? 9'h008 : 9'(8 + i), 9'(sa));
        end
        chk("cfg", 9'h085, 9'(ard));
        @(posedge core_clk);
        vin    <= 1'b1;
        en_req <= 1'b1;
        ticks(8);
        wr(1'b0, 9'h1FF);
        chk("en", 9'h000, en);
        chk("cfg", 9'h000, 9'(ard));
        ticks(16);
        chk("en", 9'h011, en);
        ticks(16);
        chk("en", 9'h017, en);
        chk("mref", 9'h001, 9'(mref));
        ticks(16);
        chk("en", 9'h037, en);
        ticks(48);
        chk("rst", 9'h000, 9'(rst_o));
        ticks(16);
        chk("rst", 9'h001, 9'(rst_o));
        chk("oe", 9'h000, 9'(rst_oe));
        chk("done", 9'h001, 9'(done));
        chk("ramp", 9'h001, 9'(ramp[0]));
        wr(1'b0, 9'h1FF);
        chk("en", 9'h1FF, en);
        @(posedge core_clk);
        sel <= 1'b1;
        ticks(1);
        chk("low", 9'h001, 9'(low));
        @(posedge core_clk);
        sel <= 1'b0;
        ticks(1);
        chk("low", 9'h000, 9'(low));
        @(posedge core_clk);
        en_req <= 1'b0;
        ticks(2);
        chk("en", 9'h008, en);
        chk("rst", 9'h000, 9'(rst_o));
        @(posedge core_clk);
        fuse <= 60'h6000000000001;
        vin  <= 1'b0;
        ticks(1);
        @(posedge core_clk);
        vin    <= 1'b1;
        en_req <= 1'b1;
        ticks(4);
        chk("done", 9'h000, 9'(done));
        @(posedge core_clk);
        en_req <= 1'b0;
        ticks(40);
        chk("en", 9'h008, en);
        ticks(32);
        chk("en", 9'h009, en);
        ticks(36);
        chk("en", 9'h008, en);
        chk("done", 9'h000, 9'(done));
        // Try-before-buy: zero fuses must not replace the shadow codes
        @(posedge core_clk);
        tbb    <= 1'b1;
        fuse   <= 60'h000000000000000;
        en_req <= 1'b1;
        ticks(2);
        @(posedge core_clk);
        en_req <= 1'b0;
        ticks(70);
        chk("en", 9'h009, en);
        end_sim();
    end
endmodule
